// File: rtl/eth_pkg.sv
package eth_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W     = 16;
    localparam int DATA_W     = 16;
    localparam int NUM_EVENTS = 8;
    localparam int TEMP_BITS  = 10;
    localparam int EXP_LIMIT  = 32;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] OFF_EVENT_FLAG      = 16'h001C;
    localparam logic [15:0] OFF_CAL_CURRENT     = 16'h004C;
    localparam logic [15:0] OFF_CAL_VOLTAGE     = 16'h0050;
    localparam logic [15:0] OFF_CAL_ACTIVE      = 16'h0052;
    localparam logic [15:0] OFF_CAL_REACTIVE    = 16'h0056;
    localparam logic [15:0] OFF_ACCUM_EXP       = 16'h005A;
    localparam logic [15:0] OFF_RSVD_A          = 16'h005C;
    localparam logic [15:0] OFF_OVERCURRENT_LIM = 16'h005E;
    localparam logic [15:0] OFF_RSVD_B          = 16'h0062;
    localparam logic [15:0] OFF_OVERPOWER_LIM   = 16'h0064;
    localparam logic [15:0] OFF_RSVD_C          = 16'h0068;
    localparam logic [15:0] OFF_FREQ_UPPER_LIM  = 16'h006A;
    localparam logic [15:0] OFF_FREQ_LOWER_LIM  = 16'h006C;
    localparam logic [15:0] OFF_TEMP_UPPER_LIM  = 16'h006E;
    localparam logic [15:0] OFF_TEMP_LOWER_LIM  = 16'h0070;
    localparam logic [15:0] OFF_VOLT_LOW_LIM    = 16'h0072;
    localparam logic [15:0] OFF_VOLT_HIGH_LIM   = 16'h0074;
    localparam logic [15:0] OFF_OVERCURRENT_HLD = 16'h0076;
    localparam logic [15:0] OFF_RSVD_D          = 16'h0078;
    localparam logic [15:0] OFF_OVERPOWER_HLD   = 16'h007A;
    localparam logic [15:0] OFF_RSVD_E          = 16'h007C;
    localparam logic [15:0] OFF_FREQ_UPPER_HLD  = 16'h007E;
    localparam logic [15:0] OFF_FREQ_LOWER_HLD  = 16'h0080;
    localparam logic [15:0] OFF_TEMP_UPPER_HLD  = 16'h0082;
    localparam logic [15:0] OFF_TEMP_LOWER_HLD  = 16'h0084;
    localparam logic [15:0] OFF_RSVD_F          = 16'h0086;
    localparam logic [15:0] OFF_EVENT_ENABLE    = 16'h008A;

    localparam logic [15:0] CFG_FIRST = OFF_CAL_CURRENT;
    localparam logic [15:0] CFG_LAST  = OFF_RSVD_F;
    localparam int          CFG_WORDS = 30;

    // ------------------------------------------------------------
    // Reset values and reserved read value
    // ------------------------------------------------------------
    localparam logic [15:0] CFG_RESET    = 16'h0000;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] RSVD_READ    = 16'h0000;

    // ------------------------------------------------------------
    // Event flag bit positions
    // ------------------------------------------------------------
    localparam int EV_OVERCURRENT = 0;
    localparam int EV_OVERPOWER   = 1;
    localparam int EV_FREQ_HIGH   = 2;
    localparam int EV_FREQ_LOW    = 3;
    localparam int EV_TEMP_HIGH   = 4;
    localparam int EV_TEMP_LOW    = 5;
    localparam int EV_VOLT_SAG    = 6;
    localparam int EV_VOLT_SURGE  = 7;

endpackage

// File: rtl/eth_hold_if.sv
`timescale 1ns/1ps
`default_nettype none

interface eth_hold_if;
    logic        tick;
    logic        breach;
    logic        enable;
    logic [15:0] hold;
    logic        flag;

    modport qual (input tick, input breach, input enable, input hold, output flag);
    modport ctrl (output tick, output breach, output enable, output hold, input flag);
endinterface

`default_nettype wire

// File: rtl/eth_hold_qual.sv
`timescale 1ns/1ps
`default_nettype none

module eth_hold_qual
    import eth_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Qualifier link
    eth_hold_if.qual  q
);

    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        flag_r;
    logic        hit;
    logic [15:0] cnt_inc;

    // Saturate so a very long breach never wraps back below the hold.
    assign cnt_inc = (cnt_r == 16'hFFFF) ? cnt_r : cnt_r + 16'h0001;
    assign hit     = q.breach && q.enable;
    assign cnt_nxt = !q.tick ? cnt_r : (hit ? cnt_inc : 16'h0000);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r  <= 16'h0000;
            flag_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            if (q.tick) begin
                flag_r <= hit && (cnt_inc >= q.hold);
            end
        end
    end

    assign q.flag = flag_r;

endmodule

`default_nettype wire

// File: rtl/eth_event_bank.sv
// Function
// - A computation cycle spans two to the power N line cycles for N up to 31.
// - Flag overcurrent when RMS current exceeds the 32-bit current limit.
// - Flag overpower when active power exceeds the 32-bit power limit.
// - Flag over and under frequency against separate 16-bit limits.
// - Flag over and under temperature against separate 16-bit limits.
// - Flag sag and surge against 16-bit RMS voltage limits.
// - Overcurrent flag waits for its hold count of consecutive cycles.
// - Overpower flag waits for its hold count of computation cycles.
// - Over and under frequency each have their own hold count.
// - Over-temperature flag waits for its own hold count.
// - Under-temperature flag waits for its separate hold count.
// - Calibration targets for current, voltage and both powers are read/write.
// - Event flags read at their own read-only 16-bit address.
// - Temperature uses the ten low bits, sampled once per computation cycle.
// - An event is recorded only when its enable bit is set.
`timescale 1ns/1ps
`default_nettype none

module eth_event_bank
    import eth_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // Register access from the serial frame decoder
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic      [DATA_W-1:0] reg_rdata,
    output logic                   reg_rvalid,
    // Measurements from the calculation engine
    input  wire logic              line_cycle,
    input  wire logic [31:0]       current_rms,
    input  wire logic [15:0]       voltage_rms,
    input  wire logic [31:0]       active_power,
    input  wire logic [15:0]       line_freq,
    input  wire logic [15:0]       temp_code,
    // Status
    output logic                   comp_tick,
    output logic      [15:0]       event_flag,
    output logic      [15:0]       accum_exponent
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    function automatic logic [4:0] idx_of(input logic [15:0] off);
        logic [15:0] d;
        d = off - CFG_FIRST;
        return d[5:1];
    endfunction

    function automatic logic is_rsvd(input logic [15:0] off);
        return (off == OFF_RSVD_A) || (off == OFF_RSVD_B) ||
               (off == OFF_RSVD_C) || (off == OFF_RSVD_D) ||
               (off == OFF_RSVD_E) || (off == OFF_RSVD_F);
    endfunction

    function automatic logic [31:0] line_cycles_for(input logic [15:0] n);
        logic [31:0] r;
        r = 32'h0000_0001 << n[4:0];
        if (n >= 16'(EXP_LIMIT)) begin
            r = 32'hFFFF_FFFF;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Configuration storage
    // ------------------------------------------------------------

    logic [15:0] cfg_mem [CFG_WORDS];
    logic [15:0] enable_r;
    logic        in_cfg;
    logic        cfg_wr;
    logic [4:0]  wr_idx;

    assign in_cfg = (reg_addr >= CFG_FIRST) && (reg_addr <= CFG_LAST) && !reg_addr[0];
    assign wr_idx = idx_of(reg_addr);
    assign cfg_wr = reg_wr && in_cfg && !is_rsvd(reg_addr);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < CFG_WORDS; i++) begin
                cfg_mem[i] <= CFG_RESET;
            end
        end else if (cfg_wr) begin
            cfg_mem[wr_idx] <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enable_r <= ENABLE_RESET;
        end else if (reg_wr && reg_addr == OFF_EVENT_ENABLE) begin
            enable_r <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // Field views
    // ------------------------------------------------------------

    wire [15:0] exp_n     = cfg_mem[idx_of(OFF_ACCUM_EXP)];
    wire [31:0] oc_lim    = {cfg_mem[idx_of(OFF_OVERCURRENT_LIM)+5'd1],
                             cfg_mem[idx_of(OFF_OVERCURRENT_LIM)]};
    wire [31:0] op_lim    = {cfg_mem[idx_of(OFF_OVERPOWER_LIM)+5'd1],
                             cfg_mem[idx_of(OFF_OVERPOWER_LIM)]};
    wire [15:0] fhi_lim   = cfg_mem[idx_of(OFF_FREQ_UPPER_LIM)];
    wire [15:0] flo_lim   = cfg_mem[idx_of(OFF_FREQ_LOWER_LIM)];
    wire [15:0] thi_lim   = cfg_mem[idx_of(OFF_TEMP_UPPER_LIM)];
    wire [15:0] tlo_lim   = cfg_mem[idx_of(OFF_TEMP_LOWER_LIM)];
    wire [15:0] vlo_lim   = cfg_mem[idx_of(OFF_VOLT_LOW_LIM)];
    wire [15:0] vhi_lim   = cfg_mem[idx_of(OFF_VOLT_HIGH_LIM)];
    wire [15:0] oc_hold   = cfg_mem[idx_of(OFF_OVERCURRENT_HLD)];
    wire [15:0] op_hold   = cfg_mem[idx_of(OFF_OVERPOWER_HLD)];
    wire [15:0] fhi_hold  = cfg_mem[idx_of(OFF_FREQ_UPPER_HLD)];
    wire [15:0] flo_hold  = cfg_mem[idx_of(OFF_FREQ_LOWER_HLD)];
    wire [15:0] thi_hold  = cfg_mem[idx_of(OFF_TEMP_UPPER_HLD)];
    wire [15:0] tlo_hold  = cfg_mem[idx_of(OFF_TEMP_LOWER_HLD)];

    // ------------------------------------------------------------
    // Computation cycle timing
    // ------------------------------------------------------------

    logic [31:0] line_cnt_r;
    logic [31:0] line_cnt_nxt;
    logic [31:0] line_cnt_inc;
    logic        tick_r;
    logic        tick_nxt;

    // Comparing with >= lets a shrinking exponent end the current
    // interval at once instead of waiting for the counter to wrap.
    assign line_cnt_inc = line_cnt_r + 32'h0000_0001;
    assign tick_nxt     = line_cycle && (line_cnt_inc >= line_cycles_for(exp_n));
    assign line_cnt_nxt = !line_cycle ? line_cnt_r :
                          (tick_nxt ? 32'h0000_0000 : line_cnt_inc);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            line_cnt_r <= 32'h0000_0000;
            tick_r     <= 1'b0;
        end else begin
            line_cnt_r <= line_cnt_nxt;
            tick_r     <= tick_nxt;
        end
    end

    // ------------------------------------------------------------
    // Limit comparisons
    // ------------------------------------------------------------

    logic [9:0]  temp_r;
    wire  [15:0] temp_val = {6'h00, temp_r};

    // The temperature code is caught once per computation cycle so the
    // limit checks see a value that stays still over the whole cycle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            temp_r <= 10'h000;
        end else if (tick_nxt) begin
            temp_r <= temp_code[TEMP_BITS-1:0];
        end
    end

    logic [NUM_EVENTS-1:0] breach;
    logic [15:0]           hold_sel [NUM_EVENTS];

    assign breach[EV_OVERCURRENT] = current_rms > oc_lim;
    assign breach[EV_OVERPOWER]   = active_power > op_lim;
    assign breach[EV_FREQ_HIGH]   = line_freq > fhi_lim;
    assign breach[EV_FREQ_LOW]    = line_freq < flo_lim;
    assign breach[EV_TEMP_HIGH]   = temp_val > thi_lim;
    assign breach[EV_TEMP_LOW]    = temp_val < tlo_lim;
    assign breach[EV_VOLT_SAG]    = voltage_rms < vlo_lim;
    assign breach[EV_VOLT_SURGE]  = voltage_rms > vhi_lim;

    // Sag and surge have no hold register and are taken on first breach.
    assign hold_sel[EV_OVERCURRENT] = oc_hold;
    assign hold_sel[EV_OVERPOWER]   = op_hold;
    assign hold_sel[EV_FREQ_HIGH]   = fhi_hold;
    assign hold_sel[EV_FREQ_LOW]    = flo_hold;
    assign hold_sel[EV_TEMP_HIGH]   = thi_hold;
    assign hold_sel[EV_TEMP_LOW]    = tlo_hold;
    assign hold_sel[EV_VOLT_SAG]    = 16'h0000;
    assign hold_sel[EV_VOLT_SURGE]  = 16'h0000;

    // ------------------------------------------------------------
    // Hold qualifiers
    // ------------------------------------------------------------

    logic [NUM_EVENTS-1:0] flag;

    for (genvar e = 0; e < NUM_EVENTS; e++) begin : g_ev
        eth_hold_if link ();

        assign link.tick   = tick_r;
        assign link.breach = breach[e];
        assign link.enable = enable_r[e];
        assign link.hold   = hold_sel[e];
        assign flag[e]     = link.flag;

        eth_hold_qual u_qual (
            .clk     (clk),
            .reset_n (reset_n),
            .q       (link)
        );
    end

    wire [15:0] flag_word = {{(16-NUM_EVENTS){1'b0}}, flag};

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------

    logic [15:0] rdata_r;
    logic        rvalid_r;
    logic [15:0] rd_mux;

    // The flag word has no write path, so writes to it fall away.
    assign rd_mux = (reg_addr == OFF_EVENT_FLAG)   ? flag_word :
                    (reg_addr == OFF_EVENT_ENABLE) ? enable_r :
                    (in_cfg && !is_rsvd(reg_addr)) ? cfg_mem[wr_idx] :
                    RSVD_READ;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r  <= 16'h0000;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_rd;
            if (reg_rd) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    logic [15:0] flag_out_r;
    logic [15:0] exp_out_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_out_r <= 16'h0000;
            exp_out_r  <= 16'h0000;
        end else begin
            flag_out_r <= flag_word;
            exp_out_r  <= exp_n;
        end
    end

    assign reg_rdata      = rdata_r;
    assign reg_rvalid     = rvalid_r;
    assign comp_tick      = tick_r;
    assign event_flag     = flag_out_r;
    assign accum_exponent = exp_out_r;

endmodule

`default_nettype wire

// File: verification/eth_engine_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Calculation engine stand-in
// ------------------------------------------------------------
// It gives one single-cycle line cycle pulse every PERIOD clocks.
// The spacing leaves room for a register read and write between ticks.
module eth_engine_model #(
    parameter int PERIOD = 8
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Line cycle strobe
    output logic      line_cycle
);
    logic [7:0] cnt_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r      <= 8'h00;
            line_cycle <= 1'b0;
        end else begin
            cnt_r      <= (cnt_r == 8'(PERIOD - 1)) ? 8'h00 : cnt_r + 8'h01;
            line_cycle <= (cnt_r == 8'(PERIOD - 1));
        end
    end
endmodule

`default_nettype wire

// File: verification/eth_event_bank_chk.sv
`timescale 1ns/1ps
`default_nettype none

module eth_event_bank_chk
    import eth_pkg::*;
(
    // Watched ports
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              reg_rvalid,
    input wire logic              line_cycle,
    input wire logic              comp_tick,
    input wire logic [15:0]       event_flag,
    input wire logic [15:0]       accum_exponent
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic exp_wr;
    assign exp_wr = reg_wr && reg_addr == OFF_ACCUM_EXP;

    sequence rd_req;
        reg_rd;
    endsequence
    sequence rd_ans;
        reg_rvalid;
    endsequence
    sequence rsvd_rd;
        reg_rd && (reg_addr == OFF_RSVD_A || reg_addr == OFF_RSVD_F);
    endsequence

    rd_answer_a: assert property (rd_req |=> rd_ans)
        else $error("read got no answer");
    ans_cause_a: assert property (rd_ans |-> $past(reg_rd))
        else $error("answer without read");
    rsvd_zero_a: assert property (rsvd_rd |=> reg_rdata == RSVD_READ)
        else $error("reserved read not zero");
    tick_cause_a: assert property (comp_tick |-> $past(line_cycle))
        else $error("tick without line cycle");
    exp_zero_a: assert property (line_cycle && accum_exponent == 16'h0000 && !reg_wr
        && !$past(reg_wr) && !$past(reg_wr, 2) |=> comp_tick)
        else $error("single line interval missed");
    exp_copy_a: assert property ($changed(accum_exponent) |-> $past(exp_wr)
        || $past(exp_wr, 2))
        else $error("exponent changed without write");
    flag_upper_a: assert property (event_flag[15:8] == 8'h00)
        else $error("unused flag bits set");
    flag_moment_a: assert property ($changed(event_flag) |-> $past(comp_tick, 2)
        || $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
        else $error("flags changed off a tick");
endmodule

bind eth_event_bank eth_event_bank_chk chk_u (.clk, .reset_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_rdata, .reg_rvalid, .line_cycle, .comp_tick, .event_flag, .accum_exponent);

`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import eth_pkg::*;

    logic        clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
    logic [15:0] reg_addr = 0, reg_wdata = 0, voltage_rms = 16'h0100, line_freq = 16'h0100;
    logic [15:0] temp_code = 16'hFD00;
    logic [31:0] current_rms = 32'h0000_0100, active_power = 32'h0000_0100;
    wire logic [15:0] reg_rdata, event_flag, accum_exponent;
    wire logic        reg_rvalid, line_cycle, comp_tick;
    int          num_errors = 0, checked = 0, cyc = 0;
    // Limit address, breaching value, quiet value and hold address per event bit.
    logic [15:0] lim_a[8] = '{16'h0060, 16'h0066, 16'h006A, 16'h006C,
                              16'h006E, 16'h0070, 16'h0072, 16'h0074};
    logic [15:0] hit_v[8] = '{16'h0000, 16'h0000, 16'h0080, 16'h0200,
                              16'h0080, 16'h0200, 16'h0200, 16'h0080};
    logic [15:0] off_v[8] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000,
                              16'hFFFF, 16'h0000, 16'h0000, 16'hFFFF};
    logic [15:0] hld_a[8] = '{16'h0076, 16'h007A, 16'h007E, 16'h0080,
                              16'h0082, 16'h0084, 16'h0000, 16'h0000};

    always #2 clk = ~clk;

    eth_event_bank dut_u (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .line_cycle(line_cycle), .current_rms(current_rms),
        .voltage_rms(voltage_rms), .active_power(active_power), .line_freq(line_freq),
        .temp_code(temp_code), .comp_tick(comp_tick), .event_flag(event_flag),
        .accum_exponent(accum_exponent));
    eth_engine_model eng_u (.clk(clk), .reset_n(reset_n), .line_cycle(line_cycle));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(negedge clk);
        reg_rd = 1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 0;
        chk("read answer", 1, reg_rvalid);
        d = reg_rdata;
    endtask
    task automatic tick;
        int n;
        @(negedge clk);
        n = 0;
        while (comp_tick !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        if (n == 500) chk("tick wait", 1, 0);
    endtask
    task automatic flags(input logic [15:0] e);
        logic [15:0] v;
        rd(OFF_EVENT_FLAG, v);
        chk("event flag word", e, v);
        chk("event flag port", e, event_flag);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic regs_test;
        logic [15:0] v;
        logic [15:0] ro[4] = '{16'h001C, 16'h005C, 16'h0062, 16'h0086};
        for (logic [15:0] a = 16'h004C; a <= 16'h0058; a += 16'h0002) begin
            rd(a, v);
            chk("reset value", 0, v);
            wr(a, 16'hA500 + a);
            rd(a, v);
            chk("calibration target", 16'hA500 + a, v);
        end
        foreach (ro[i]) begin
            wr(ro[i], 16'hFFFF);
            rd(ro[i], v);
            chk("read-only or reserved", 0, v);
        end
    endtask
    task automatic exp_test;
        int n;
        wr(OFF_ACCUM_EXP, 16'h0003);
        tick;
        n = 0;
        do begin
            @(negedge clk);
            if (line_cycle === 1'b1) n++;
        end while (comp_tick !== 1'b1 && n < 100);
        chk("line cycles per interval", 8, 32'(n));
        chk("exponent port", 3, accum_exponent);
        wr(OFF_ACCUM_EXP, 16'h0000);
        tick;
    endtask
    task automatic ev_test;
        logic [15:0] b, e1;
        for (int i = 0; i < 8; i++) begin
            b = 16'h0001 << i;
            e1 = (hld_a[i] == 0) ? b : 16'h0000;
            if (hld_a[i] != 0) wr(hld_a[i], 16'h0002);
            wr(lim_a[i], hit_v[i]);
            tick;
            flags(e1);
            wr(lim_a[i], off_v[i]);
            tick;
            flags(0);
            wr(lim_a[i], hit_v[i]);
            tick;
            flags(e1);
            tick;
            flags(b);
            wr(lim_a[i], off_v[i]);
            tick;
            flags(0);
        end
    endtask
    task automatic en_test;
        wr(OFF_EVENT_ENABLE, 16'h00FE);
        wr(16'h0060, 16'h0000);
        // A limit just under the current only breaches if the high half is cleared to zero first.
        wr(OFF_OVERCURRENT_LIM, 16'h00FF);
        repeat (3) tick;
        flags(0);
        wr(OFF_EVENT_ENABLE, 16'h00FF);
        tick;
        tick;
        flags(16'h0001);
    endtask
    task automatic temp_test;
        wr(16'h0060, 16'hFFFF);
        wr(OFF_TEMP_UPPER_HLD, 16'h0001);
        wr(OFF_TEMP_UPPER_LIM, 16'h0180);
        tick;
        // A code that moves after the interval end must not be seen until the next one.
        temp_code = 16'h0200;
        flags(16'h0000);
        tick;
        flags(16'h0010);
        temp_code = 16'hFD00;
        wr(OFF_TEMP_UPPER_LIM, 16'hFFFF);
        tick;
        flags(16'h0000);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            conclude;
        end
    end

    initial begin
        repeat (10) @(negedge clk);
        reset_n = 1;
        regs_test;
        exp_test;
        foreach (off_v[i]) wr(lim_a[i], off_v[i]);
        wr(OFF_EVENT_ENABLE, 16'h00FF);
        tick;
        tick;
        flags(0);
        ev_test;
        en_test;
        temp_test;
        conclude;
    end
endmodule

`default_nettype wire
